// *** cil_defs.svh ***
// Purpose: Shared widths and field positions of the cycle sequencer
// Assumes: Included by its bare name
// Notes:   Definitions only
`ifndef CIL_DEFS_SVH
`define CIL_DEFS_SVH

`define CIL_CNT_W        6
`define CIL_REG_W        4
`define CIL_NREG         16
`define CIL_WORD_W       32
`define CIL_BUSY_W       4
`define CIL_WCNT_W       5
`define CIL_ARM_MSEL_HI  11
`define CIL_ARM_MSEL_LO  8
`define CIL_T16_MSEL_HI  2
`define CIL_T16_MSEL_LO  0
`define CIL_MTERM_1      8
`define CIL_MTERM_2      16
`define CIL_MTERM_3      24
`define CIL_PC_CYCLES    6'h05
`define CIL_LDM_PC_ADD   6'h04

`endif

// *** cil_mem_model.sv ***
// Purpose: Cache-side stall model for the sequencer's memory buses
// Assumes: miss_go is a one-cycle request from the bench
// Notes:   Length zero answers at once; longer lengths model a miss
`timescale 1ns/1ns
module cil_mem_model
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       miss_go,
  input  wire logic [3:0] miss_len,
  output logic            mem_wait
);
  logic [3:0] left_q;

  // A new miss restarts the count
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      left_q <= 4'h0;
    else if (miss_go)
      left_q <= miss_len;
    else if (left_q != 4'h0)
      left_q <= left_q - 4'h1;
  end
  assign mem_wait = left_q != 4'h0;
endmodule

// *** cil_pkg.sv ***
// Purpose: Types of the cycle sequencer
// Assumes: Nothing
// Notes:   Constants live in cil_defs.svh
package cil_pkg;

  typedef enum logic [3:0] {
    CIL_DATA_OP,
    CIL_LOAD_SINGLE,
    CIL_STORE_SINGLE,
    CIL_LOAD_MULTIPLE,
    CIL_STORE_MULTIPLE,
    CIL_SWAP_MEM,
    CIL_COPRO_DATA_OP,
    CIL_COPRO_LOAD_STORE,
    CIL_CORE_TO_COPRO_MOVE,
    CIL_COPRO_TO_CORE_MOVE,
    CIL_MULTIPLY_32,
    CIL_MULTIPLY_LONG
  } cil_class_e;

  typedef enum logic [1:0] {
    CIL_CYC_I,
    CIL_CYC_S,
    CIL_CYC_N,
    CIL_CYC_C
  } cil_bus_e;

  typedef enum logic [0:0] {
    CIL_ST_IDLE,
    CIL_ST_RUN
  } cil_state_e;

endpackage

// *** cil_timing.sv ***
// Purpose: Cycle accounting and interlock control of a five-stage core
// Assumes: Accesses hit in cache; mem_wait comes from same-clock logic
// Notes:   One instruction in flight; outputs describe the current cycle
`timescale 1ns/1ns
`include "cil_defs.svh"

module cil_timing
(
  input  wire logic                             clk_sys,
  input  wire logic                             rst,
  input  wire logic                             issue_valid,
  input  wire cil_pkg::cil_class_e              issue_class,
  input  wire logic                             shift_by_reg,
  input  wire logic                             loads_pc,
  input  wire logic                             subword_load,
  input  wire logic [`CIL_REG_W-1:0]            dest_reg,
  input  wire logic [`CIL_NREG-1:0]             xfer_list,
  input  wire logic [`CIL_WCNT_W-1:0]           copro_words,
  input  wire logic [`CIL_BUSY_W-1:0]           copro_busy,
  input  wire logic                             mul_unsigned,
  input  wire logic                             short_encoding,
  input  wire logic [`CIL_WORD_W-1:0]           instr_word,
  input  wire logic [`CIL_NREG*`CIL_WORD_W-1:0] reg_values,
  input  wire logic [`CIL_REG_W-1:0]            next_src_a,
  input  wire logic                             next_src_a_used,
  input  wire logic [`CIL_REG_W-1:0]            next_src_b,
  input  wire logic                             next_src_b_used,
  input  wire logic                             mem_wait,
  output logic                                  issue_ready,
  output cil_pkg::cil_bus_e                     ibus_cycle,
  output cil_pkg::cil_bus_e                     dbus_cycle,
  output logic                                  fetch_en,
  output logic                                  interlock,
  output logic                                  instr_last
);

  cil_pkg::cil_state_e     state_q, state_d;
  cil_pkg::cil_class_e     cls_q, cls_d;
  logic [`CIL_CNT_W-1:0]   idx_q, idx_d;
  logic [`CIL_CNT_W-1:0]   total_q, total_d;
  logic [`CIL_CNT_W-1:0]   nwords_q, nwords_d;
  logic [`CIL_CNT_W-1:0]   busy_q, busy_d;
  logic                    pc_q, pc_d;
  logic [1:0]              ilk_q, ilk_d;
  logic                    ready_q, ready_d;
  cil_pkg::cil_bus_e       ibus_q, ibus_d;
  cil_pkg::cil_bus_e       dbus_q, dbus_d;
  logic                    fetch_q, fetch_d;
  logic                    intl_q, intl_d;
  logic                    last_q, last_d;

  logic                    accept;
  logic [`CIL_REG_W-1:0]   msel;
  logic [`CIL_WORD_W-1:0]  mop;
  logic [2:0]              mterm;
  logic [`CIL_CNT_W-1:0]   popc;
  logic [`CIL_CNT_W-1:0]   nx;
  logic [`CIL_REG_W-1:0]   top_reg;
  logic                    dep_dest;
  logic                    dep_top;
  logic [`CIL_CNT_W-1:0]   bx;
  logic [`CIL_CNT_W-1:0]   wx;

  function automatic logic src_hits(input logic [`CIL_REG_W-1:0] r);
    src_hits = (next_src_a_used && next_src_a == r) ||
               (next_src_b_used && next_src_b == r);
  endfunction

  // Early termination of the multiplier array
  function automatic logic [2:0] early_m(input logic [`CIL_WORD_W-1:0] op,
                                         input logic                   uns);
    logic z1;
    logic z2;
    logic z3;
    z1 = (op[`CIL_WORD_W-1:`CIL_MTERM_1] == '0) ||
         (!uns && (&op[`CIL_WORD_W-1:`CIL_MTERM_1]));
    z2 = (op[`CIL_WORD_W-1:`CIL_MTERM_2] == '0) ||
         (!uns && (&op[`CIL_WORD_W-1:`CIL_MTERM_2]));
    z3 = (op[`CIL_WORD_W-1:`CIL_MTERM_3] == '0) ||
         (!uns && (&op[`CIL_WORD_W-1:`CIL_MTERM_3]));
    if (z1)
      early_m = 3'h1;
    else if (z2)
      early_m = 3'h2;
    else if (z3)
      early_m = 3'h3;
    else
      early_m = 3'h4;
  endfunction

  // Operand register and its value
  always_comb
  begin
    msel = short_encoding ?
           {1'b0, instr_word[`CIL_T16_MSEL_HI:`CIL_T16_MSEL_LO]} :
           instr_word[`CIL_ARM_MSEL_HI:`CIL_ARM_MSEL_LO];
    mop   = reg_values[{msel, 5'h00} +: `CIL_WORD_W];
    mterm = early_m(mop, mul_unsigned && issue_class ==
                    cil_pkg::CIL_MULTIPLY_LONG);
  end

  // Register list count and highest listed register
  always_comb
  begin
    popc    = '0;
    top_reg = '0;
    for (int i = 0; i < `CIL_NREG; i++)
    begin
      popc = popc + {{(`CIL_CNT_W-1){1'b0}}, xfer_list[i]};
      if (xfer_list[i])
        top_reg = i[`CIL_REG_W-1:0];
    end
    nx       = (popc == '0) ? 6'h01 : popc;
    bx       = {{(`CIL_CNT_W-`CIL_BUSY_W){1'b0}}, copro_busy};
    wx       = {{(`CIL_CNT_W-`CIL_WCNT_W){1'b0}}, copro_words};
    dep_dest = src_hits(dest_reg);
    dep_top  = src_hits(top_reg);
  end

  assign accept = issue_valid && ready_q && !mem_wait;

  // Sequencer next state
  always_comb
  begin
    state_d  = state_q;
    cls_d    = cls_q;
    idx_d    = idx_q;
    total_d  = total_q;
    nwords_d = nwords_q;
    busy_d   = busy_q;
    pc_d     = pc_q;
    ilk_d    = ilk_q;
    if (accept)
    begin
      state_d  = cil_pkg::CIL_ST_RUN;
      cls_d    = issue_class;
      idx_d    = '0;
      nwords_d = nx;
      busy_d   = bx;
      pc_d     = loads_pc;
      ilk_d    = 2'h0;
      total_d  = 6'h01;
      case (issue_class)
        cil_pkg::CIL_DATA_OP:
          total_d = shift_by_reg ? 6'h02 : 6'h01;
        cil_pkg::CIL_LOAD_SINGLE:
        begin
          if (loads_pc)
            total_d = `CIL_PC_CYCLES;
          else
          begin
            ilk_d   = dep_dest ? (subword_load ? 2'h2 : 2'h1) : 2'h0;
            total_d = 6'h01 + {4'h0, ilk_d};
          end
        end
        cil_pkg::CIL_STORE_SINGLE:
          total_d = 6'h01;
        cil_pkg::CIL_LOAD_MULTIPLE:
        begin
          // Earlier registers arrive before the last transfer starts
          ilk_d = (dep_top && !loads_pc) ? 2'h1 : 2'h0;
          if (loads_pc)
            total_d = nx + `CIL_LDM_PC_ADD;
          else
            total_d = ((nx == 6'h01) ? 6'h02 : nx) + {4'h0, ilk_d};
        end
        cil_pkg::CIL_STORE_MULTIPLE:
        begin
          pc_d    = 1'b0;
          total_d = (nx == 6'h01) ? 6'h02 : nx;
        end
        cil_pkg::CIL_SWAP_MEM:
        begin
          ilk_d   = (dep_dest && subword_load) ? 2'h1 : 2'h0;
          total_d = 6'h02 + {4'h0, ilk_d};
        end
        cil_pkg::CIL_COPRO_DATA_OP,
        cil_pkg::CIL_CORE_TO_COPRO_MOVE:
          total_d = bx + 6'h01;
        cil_pkg::CIL_COPRO_LOAD_STORE:
        begin
          nwords_d = (wx == '0) ? 6'h01 : wx;
          total_d  = bx + nwords_d;
        end
        cil_pkg::CIL_COPRO_TO_CORE_MOVE:
        begin
          ilk_d   = dep_dest ? 2'h1 : 2'h0;
          total_d = bx + 6'h01 + {4'h0, ilk_d};
        end
        cil_pkg::CIL_MULTIPLY_32:
          total_d = 6'h02 + {3'h0, mterm};
        cil_pkg::CIL_MULTIPLY_LONG:
          total_d = 6'h03 + {3'h0, mterm};
        default:
          total_d = 6'h01;
      endcase
    end
    else if (state_q == cil_pkg::CIL_ST_RUN && !mem_wait)
    begin
      if (idx_q == total_q - 6'h01)
        state_d = cil_pkg::CIL_ST_IDLE;
      else
        idx_d = idx_q + 6'h01;
    end
  end

  // Bus cycle types and flags for the coming cycle
  always_comb
  begin
    ibus_d  = cil_pkg::CIL_CYC_I;
    dbus_d  = cil_pkg::CIL_CYC_I;
    intl_d  = 1'b0;
    last_d  = 1'b0;
    ready_d = 1'b1;
    fetch_d = 1'b0;
    if (state_d == cil_pkg::CIL_ST_RUN)
    begin
      last_d  = (idx_d == total_d - 6'h01);
      ready_d = last_d;
      if (idx_d == '0)
        ibus_d = cil_pkg::CIL_CYC_S;
      if (pc_d && cls_d == cil_pkg::CIL_LOAD_SINGLE)
      begin
        if (idx_d == 6'h03)
          ibus_d = cil_pkg::CIL_CYC_N;
        else if (idx_d == 6'h04)
          ibus_d = cil_pkg::CIL_CYC_S;
      end
      if (pc_d && cls_d == cil_pkg::CIL_LOAD_MULTIPLE)
      begin
        if (idx_d == total_d - 6'h02)
          ibus_d = cil_pkg::CIL_CYC_N;
        else if (idx_d == total_d - 6'h01)
          ibus_d = cil_pkg::CIL_CYC_S;
      end
      case (cls_d)
        cil_pkg::CIL_LOAD_SINGLE:
          dbus_d = (idx_d == '0) ? cil_pkg::CIL_CYC_N : cil_pkg::CIL_CYC_I;
        cil_pkg::CIL_STORE_SINGLE:
          dbus_d = cil_pkg::CIL_CYC_N;
        cil_pkg::CIL_LOAD_MULTIPLE,
        cil_pkg::CIL_STORE_MULTIPLE:
        begin
          if (idx_d == '0)
            dbus_d = (nwords_d == 6'h01 && !pc_d &&
                      cls_d == cil_pkg::CIL_LOAD_MULTIPLE) ?
                     cil_pkg::CIL_CYC_S : cil_pkg::CIL_CYC_N;
          else if (idx_d < nwords_d)
            dbus_d = cil_pkg::CIL_CYC_S;
          else
            dbus_d = cil_pkg::CIL_CYC_I;
        end
        cil_pkg::CIL_SWAP_MEM:
          dbus_d = (idx_d < 6'h02) ? cil_pkg::CIL_CYC_N : cil_pkg::CIL_CYC_I;
        cil_pkg::CIL_COPRO_LOAD_STORE:
        begin
          if (idx_d < busy_d)
            dbus_d = cil_pkg::CIL_CYC_I;
          else if (idx_d == busy_d)
            dbus_d = cil_pkg::CIL_CYC_N;
          else
            dbus_d = cil_pkg::CIL_CYC_S;
        end
        cil_pkg::CIL_CORE_TO_COPRO_MOVE,
        cil_pkg::CIL_COPRO_TO_CORE_MOVE:
          dbus_d = last_d ? cil_pkg::CIL_CYC_C : cil_pkg::CIL_CYC_I;
        default:
          dbus_d = cil_pkg::CIL_CYC_I;
      endcase
      // Copro move interlock precedes C; none while the first cycle fetches
      if (ilk_d != 2'h0)
      begin
        if (cls_d == cil_pkg::CIL_COPRO_TO_CORE_MOVE)
          intl_d = (idx_d == busy_d) && (idx_d != '0) && !last_d;
        else
          intl_d = (idx_d >= total_d - {4'h0, ilk_d});
      end
      // Fetch only in S or N instruction-bus cycles outside interlock
      fetch_d = (ibus_d != cil_pkg::CIL_CYC_I) && !intl_d;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_q  <= cil_pkg::CIL_ST_IDLE;
      cls_q    <= cil_pkg::CIL_DATA_OP;
      idx_q    <= '0;
      total_q  <= 6'h01;
      nwords_q <= 6'h01;
      busy_q   <= '0;
      pc_q     <= 1'b0;
      ilk_q    <= 2'h0;
      ready_q  <= 1'b1;
      ibus_q   <= cil_pkg::CIL_CYC_I;
      dbus_q   <= cil_pkg::CIL_CYC_I;
      fetch_q  <= 1'b0;
      intl_q   <= 1'b0;
      last_q   <= 1'b0;
    end
    else
    begin
      state_q  <= state_d;
      cls_q    <= cls_d;
      idx_q    <= idx_d;
      total_q  <= total_d;
      nwords_q <= nwords_d;
      busy_q   <= busy_d;
      pc_q     <= pc_d;
      ilk_q    <= ilk_d;
      ready_q  <= ready_d;
      ibus_q   <= ibus_d;
      dbus_q   <= dbus_d;
      fetch_q  <= fetch_d;
      intl_q   <= intl_d;
      last_q   <= last_d;
    end
  end

  assign issue_ready = ready_q;
  assign ibus_cycle  = ibus_q;
  assign dbus_cycle  = dbus_q;
  assign fetch_en    = fetch_q;
  assign interlock   = intl_q;
  assign instr_last  = last_q;

endmodule

// *** cil_timing_checker.sv ***
// Purpose: Port assertions of the cycle sequencer
// Assumes: Bound into cil_timing
// Notes:   Cycles held by mem_wait are exempt where noted
`timescale 1ns/1ns
module cil_timing_checker
(
  input wire logic              clk_sys,
  input wire logic              rst,
  input wire logic              issue_valid,
  input wire logic              mem_wait,
  input wire logic              issue_ready,
  input wire cil_pkg::cil_bus_e ibus_cycle,
  input wire cil_pkg::cil_bus_e dbus_cycle,
  input wire logic              fetch_en,
  input wire logic              interlock,
  input wire logic              instr_last
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire take = issue_valid && issue_ready && !mem_wait;
  wire ib_i = ibus_cycle == cil_pkg::CIL_CYC_I;
  wire ib_s = ibus_cycle == cil_pkg::CIL_CYC_S;
  wire db_i = dbus_cycle == cil_pkg::CIL_CYC_I;

  lock_fetch_a: assert property (interlock |-> !fetch_en)
    else $error("fetch in interlock");
  fetch_bus_a: assert property (fetch_en == (!interlock && !ib_i))
    else $error("fetch_en not tied to bus");
  lock_idle_a: assert property (interlock |-> ib_i && db_i)
    else $error("interlock cycle not idle");
  first_seq_a: assert property (take |=> ib_s)
    else $error("first fetch not sequential");
  lock_end_a: assert property (interlock && !instr_last && !mem_wait
    |=> instr_last) else $error("interlock not at end");
  wait_hold_a: assert property (mem_wait && !issue_ready
    |=> $stable(ibus_cycle) && $stable(dbus_cycle))
    else $error("outputs moved in stall");
  busy_ready_a: assert property (take |=> !issue_ready || instr_last)
    else $error("ready while busy");
  end_bound_a: assert property (take |=> ##[0:63] instr_last)
    else $error("instruction did not end");
  c_last_a: assert property (dbus_cycle == cil_pkg::CIL_CYC_C
    |-> instr_last) else $error("C cycle not last");

  // Stall inside an instruction is the awkward case worth seeing
  cover property (interlock ##1 interlock);
  cover property (mem_wait && !issue_ready);
  cover property (dbus_cycle == cil_pkg::CIL_CYC_C);
endmodule

bind cil_timing cil_timing_checker u_chk
(
  .clk_sys, .rst, .issue_valid, .mem_wait, .issue_ready,
  .ibus_cycle, .dbus_cycle, .fetch_en, .interlock, .instr_last
);

// *** cil_timing_tb_top.sv ***
// Purpose: Self-checking bench of the cycle sequencer
// Assumes: Stall model drives mem_wait; hits unless a miss is asked
// Notes:   Bus cycles logged as letters; stalled repeats skipped
`timescale 1ns/1ns
`include "cil_defs.svh"
module cil_timing_tb_top;
  logic                      clk_sys = 1'h0;
  logic                      rst = 1'h1;
  logic                      issue_valid, shift_by_reg, loads_pc;
  logic                      subword_load, mul_unsigned, short_encoding;
  logic                      next_src_a_used, next_src_b_used, miss_go;
  cil_pkg::cil_class_e       issue_class;
  logic [`CIL_REG_W-1:0]     dest_reg, next_src_a, next_src_b;
  logic [`CIL_NREG-1:0]      xfer_list;
  logic [`CIL_WCNT_W-1:0]    copro_words;
  logic [`CIL_BUSY_W-1:0]    copro_busy;
  logic [`CIL_WORD_W-1:0]    instr_word;
  logic [16*`CIL_WORD_W-1:0] reg_values;
  logic [3:0]                miss_len;
  logic                      mem_wait, issue_ready, fetch_en, interlock;
  logic                      instr_last;
  cil_pkg::cil_bus_e         ibus_cycle, dbus_cycle;
  int                        err_total = 0;
  int                        n_tests = 0;
  int                        cyc = 0;
  int                        miss_at, ncyc;

  always #5 clk_sys = ~clk_sys;

  cil_timing dut
  (
    .clk_sys, .rst, .issue_valid, .issue_class, .shift_by_reg, .loads_pc,
    .subword_load, .dest_reg, .xfer_list, .copro_words, .copro_busy,
    .mul_unsigned, .short_encoding, .instr_word, .reg_values, .next_src_a,
    .next_src_a_used, .next_src_b, .next_src_b_used, .mem_wait,
    .issue_ready, .ibus_cycle, .dbus_cycle, .fetch_en, .interlock,
    .instr_last
  );
  cil_mem_model u_mem
  (
    .clk_sys, .rst, .miss_go, .miss_len, .mem_wait
  );

  task automatic tally_and_finish();
    if (err_total == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Whole run needs under a thousand cycles
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      err_total++;
      tally_and_finish();
    end
  end

  function automatic string enc(cil_pkg::cil_bus_e v);
    case (v)
      cil_pkg::CIL_CYC_I: return "I";
      cil_pkg::CIL_CYC_S: return "S";
      cil_pkg::CIL_CYC_N: return "N";
      cil_pkg::CIL_CYC_C: return "C";
      default: return "X";
    endcase
  endfunction

  function automatic string rep(string c, int n);
    string s = "";
    repeat (n) s = {s, c};
    return s;
  endfunction

  task automatic chk(string nm, string e, string g);
    n_tests++;
    if (g != e)
    begin
      $display("[ERR] %s expected %s seen %s", nm, e, g);
      err_total++;
    end
  endtask

  task automatic clr();
    {issue_valid, shift_by_reg, loads_pc, subword_load, mul_unsigned} = '0;
    {short_encoding, next_src_a_used, next_src_b_used, miss_go} = '0;
    {dest_reg, next_src_a, next_src_b, xfer_list, copro_words} = '0;
    {copro_busy, instr_word, reg_values, miss_len} = '0;
    issue_class = cil_pkg::CIL_DATA_OP;
    miss_at = -1;
  endtask

  // Entered at a falling edge; returns at the one showing the last cycle
  task automatic go(cil_pkg::cil_class_e c, string nm, string ei, string ed);
    string gi = "";
    string gd = "";
    int k = 0;
    bit done = 1'b0;
    issue_class = c;
    issue_valid = 1'h1;
    @(negedge clk_sys);
    issue_valid = 1'h0;
    while (k < 80)
    begin
      miss_go = (k == miss_at);
      if (mem_wait === 1'h0)
      begin
        gi = {gi, enc(ibus_cycle)};
        gd = {gd, enc(dbus_cycle)};
      end
      k++;
      done = (instr_last === 1'h1 && mem_wait === 1'h0);
      if (done)
        break;
      @(negedge clk_sys);
    end
    ncyc = k;
    miss_go = 1'h0;
    chk({nm, " end"}, "1", done ? "1" : "0");
    chk({nm, " ibus"}, ei, gi);
    chk({nm, " dbus"}, ed, gd);
  endtask

  task automatic t_load();
    clr();
    shift_by_reg = 1'h1;
    go(cil_pkg::CIL_DATA_OP, "dop sh", "SI", "II");
    dest_reg = 4'h2;
    next_src_a = 4'h2;
    go(cil_pkg::CIL_LOAD_SINGLE, "ld", "S", "N");
    next_src_a_used = 1'h1;
    go(cil_pkg::CIL_LOAD_SINGLE, "ld use", "SI", "NI");
    go(cil_pkg::CIL_STORE_SINGLE, "st", "S", "N");
    {next_src_a_used, next_src_b_used, subword_load} = 3'h7;
    next_src_b = 4'h2;
    go(cil_pkg::CIL_LOAD_SINGLE, "ldb use", "SII", "NII");
    next_src_b = 4'h3;
    next_src_a_used = 1'h0;
    go(cil_pkg::CIL_LOAD_SINGLE, "ldb free", "S", "N");
    next_src_b = 4'h2;
    go(cil_pkg::CIL_SWAP_MEM, "swpb use", "SII", "NNI");
    subword_load = 1'h0;
    go(cil_pkg::CIL_SWAP_MEM, "swp", "SI", "NN");
  endtask

  task automatic t_multi();
    clr();
    loads_pc = 1'h1;
    go(cil_pkg::CIL_LOAD_SINGLE, "ldpc", "SIINS", "NIIII");
    {miss_len, miss_at} = {4'h3, 32'h1};
    go(cil_pkg::CIL_LOAD_SINGLE, "ldpc miss", "SIINS", "NIIII");
    chk("ldpc len", "8", $sformatf("%0d", ncyc));
    clr();
    xfer_list = 16'h0002;
    go(cil_pkg::CIL_LOAD_MULTIPLE, "ldm1", "SI", "SI");
    go(cil_pkg::CIL_STORE_MULTIPLE, "stm1", "SI", "NI");
    xfer_list = 16'hffff;
    go(cil_pkg::CIL_STORE_MULTIPLE, "stm16", {"S", rep("I", 15)},
       {"N", rep("S", 15)});
    {xfer_list, next_src_a, next_src_a_used} = {16'h000e, 4'h1, 1'h1};
    go(cil_pkg::CIL_LOAD_MULTIPLE, "ldm lo", "SII", "NSS");
    next_src_a = 4'h3;
    go(cil_pkg::CIL_LOAD_MULTIPLE, "ldm hi", "SIII", "NSSI");
    {xfer_list, loads_pc} = {16'h8006, 1'h1};
    go(cil_pkg::CIL_LOAD_MULTIPLE, "ldm pc", "SIIIINS", "NSSIIII");
  endtask

  task automatic t_copro();
    for (int b = 0; b < 16; b += 7)
    begin
      clr();
      copro_busy = 4'(b);
      copro_words = 5'h03;
      go(cil_pkg::CIL_COPRO_DATA_OP, "cdp", {"S", rep("I", b)},
         rep("I", b + 1));
      go(cil_pkg::CIL_COPRO_LOAD_STORE, "cls",
         {"S", rep("I", b + 2)}, {rep("I", b), "NSS"});
      go(cil_pkg::CIL_CORE_TO_COPRO_MOVE, "c2c", {"S", rep("I", b)},
         {rep("I", b), "C"});
      {dest_reg, next_src_a, next_src_a_used} = {4'h4, 4'h4, 1'h1};
      go(cil_pkg::CIL_COPRO_TO_CORE_MOVE, "mrc",
         {"S", rep("I", b + 1)}, {rep("I", b + 1), "C"});
    end
  endtask

  task automatic t_mul();
    logic [31:0] op [11] = '{32'h00000012, 32'hffffff80, 32'h00001234,
      32'hffff8000, 32'h00123456, 32'hff800000, 32'h12345678, 32'hffffff80,
      32'h00000012, 32'h00001234, 32'h00123456};
    // Unsigned, long, then m minus one
    logic [3:0] cf [11] = '{4'h0, 4'h0, 4'h5, 4'h1, 4'h2, 4'h6, 4'h3, 4'hf,
      4'hc, 4'hd, 4'he};
    int t;
    cil_pkg::cil_class_e mc;
    clr();
    instr_word = 32'h00000500;
    reg_values[3*32 +: 32] = 32'h12345678;
    for (int i = 0; i < 11; i++)
    begin
      reg_values[5*32 +: 32] = op[i];
      mul_unsigned = cf[i][3];
      t = (cf[i][2] ? 4 : 3) + cf[i][1:0];
      mc = cf[i][2] ? cil_pkg::CIL_MULTIPLY_LONG : cil_pkg::CIL_MULTIPLY_32;
      go(mc, $sformatf("mul%0d", i), {"S", rep("I", t - 1)},
         rep("I", t));
    end
    {short_encoding, instr_word} = {1'h1, 32'h00000503};
    reg_values[3*32 +: 32] = 32'h00000012;
    go(cil_pkg::CIL_MULTIPLY_32, "mul16", "SII", "III");
  endtask

  task automatic t_refuse();
    bit seen = 1'b0;
    clr();
    {miss_len, miss_go} = {4'h3, 1'h1};
    @(negedge clk_sys);
    {miss_go, issue_valid} = 2'h1;
    @(negedge clk_sys);
    issue_valid = 1'h0;
    repeat (4)
    begin
      seen |= (instr_last !== 1'h0);
      @(negedge clk_sys);
    end
    chk("refused", "0", $sformatf("%0d", seen));
  endtask

  initial
  begin
    clr();
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("reset", "II1000", {enc(ibus_cycle), enc(dbus_cycle),
        $sformatf("%b%b%b%b", issue_ready, fetch_en, interlock, instr_last)});
    rst = 1'h0;
    go(cil_pkg::CIL_DATA_OP, "dop", "S", "I");
    t_load();
    t_multi();
    t_copro();
    t_mul();
    t_refuse();
    tally_and_finish();
  end
endmodule
